// File: common/opaf_pkg.sv
// package: constants, modes and register map for the operand address and flags block
package opaf_pkg;

  // ==========================================================
  // register map (byte addresses on apb)
  localparam logic [11:0] OPAF_OFS_FLAGS   = 12'h000;
  localparam logic [11:0] OPAF_OFS_MODE    = 12'h004;
  localparam logic [11:0] OPAF_OFS_INDEX   = 12'h008;
  localparam logic [11:0] OPAF_OFS_STACK   = 12'h00C;
  localparam logic [11:0] OPAF_OFS_NEXTPC  = 12'h010;
  localparam logic [11:0] OPAF_OFS_OPBYTES = 12'h014;
  localparam logic [11:0] OPAF_OFS_EA      = 12'h018;
  localparam logic [11:0] OPAF_OFS_ALU     = 12'h01C;
  localparam logic [11:0] OPAF_OFS_RESULT  = 12'h020;
  localparam logic [11:0] OPAF_OFS_MEMWORD = 12'h024;
  localparam logic [11:0] OPAF_OFS_POLICY  = 12'h028;

  // ==========================================================
  // condition flag layout
  localparam int OPAF_FLAG_V = 7;
  localparam int OPAF_FLAG_H = 4;
  localparam int OPAF_FLAG_I = 3;
  localparam int OPAF_FLAG_N = 2;
  localparam int OPAF_FLAG_Z = 1;
  localparam int OPAF_FLAG_C = 0;
  // bits 6 and 5 always read as one
  localparam logic [7:0] OPAF_FLAGS_ONES  = 8'h60;
  localparam logic [7:0] OPAF_FLAGS_RESET = 8'h68;

  // direct page high byte
  localparam logic [7:0] OPAF_DIRECT_PAGE = 8'h00;
  localparam logic [31:0] OPAF_SLVERR_NONE = 32'h0000_0000;

  // ==========================================================
  // addressing modes
  typedef enum logic [3:0] {
    OPAF_NO_OPERAND_MODE        = 4'h0,
    OPAF_LITERAL_MODE           = 4'h1,
    OPAF_DIRECT_MODE            = 4'h2,
    OPAF_FULL_ADDRESS_MODE      = 4'h3,
    OPAF_POINTER_PLAIN_MODE     = 4'h4,
    OPAF_POINTER_AUTOINC_MODE   = 4'h5,
    OPAF_POINTER_SHORT_MODE     = 4'h6,
    OPAF_POINTER_SHORT_INC_MODE = 4'h7,
    OPAF_POINTER_LONG_MODE      = 4'h8,
    OPAF_STACK_SHORT_MODE       = 4'h9,
    OPAF_STACK_LONG_MODE        = 4'hA,
    OPAF_RELATIVE_MODE          = 4'hB
  } opaf_mode_e;

  // instruction class, needed for post-increment legality
  typedef enum logic [1:0] {
    OPAF_CLASS_OTHER    = 2'h0,
    OPAF_CLASS_CMP_BEQ  = 2'h1,
    OPAF_CLASS_MEM_MOVE = 2'h2
  } opaf_class_e;

  // per-flag update policy, two bits per flag
  typedef enum logic [1:0] {
    OPAF_POL_KEEP   = 2'h0,
    OPAF_POL_ZERO   = 2'h1,
    OPAF_POL_ONE    = 2'h2,
    OPAF_POL_RESULT = 2'h3
  } opaf_pol_e;

  // alu operations
  typedef enum logic [1:0] {
    OPAF_ALU_ADD = 2'h0,
    OPAF_ALU_ADC = 2'h1,
    OPAF_ALU_SUB = 2'h2,
    OPAF_ALU_SBC = 2'h3
  } opaf_alu_e;

  // sequencer for the flag update step
  typedef enum logic [1:0] {
    OPAF_ST_IDLE   = 2'b00,
    OPAF_ST_APPLY  = 2'b01,
    OPAF_ST_DONE   = 2'b11
  } opaf_state_e;

  // 16-bit word from two bytes, first byte is the high byte
  function automatic logic [15:0] opaf_join(input logic [7:0] first_b,
                                            input logic [7:0] second_b);
    opaf_join = {first_b, second_b};
  endfunction : opaf_join

endpackage : opaf_pkg

// File: hdl/opaf_ea_calc.sv
// combinational effective address former for every addressing mode
`timescale 1ns/1ns
module opaf_ea_calc
  import opaf_pkg::*;
(
  input  wire logic [3:0]  mode,
  input  wire logic [1:0]  iclass,
  input  wire logic [15:0] index_pair,
  input  wire logic [15:0] stack_ptr,
  input  wire logic [15:0] next_pc,
  input  wire logic [7:0]  byte1,
  input  wire logic [7:0]  byte2,
  output logic      [15:0] eff_addr,
  output logic      [15:0] index_after,
  output logic             mode_illegal
);

  logic [15:0] long_off;
  logic [15:0] short_off;
  logic [15:0] rel_off;

  always_comb
  begin
    long_off     = opaf_join(byte1, byte2);                     // RULE_10
    short_off    = {8'h00, byte1};                              // RULE_09
    // last machine byte is the signed displacement
    rel_off      = {{8{byte1[7]}}, byte1};                      // RULE_07
    eff_addr     = 16'h0000;
    index_after  = index_pair;
    mode_illegal = 1'b0;
    // all sums are 16 bits wide so they wrap with no fault
    case (opaf_mode_e'(mode))                                    // RULE_16
      OPAF_NO_OPERAND_MODE:   eff_addr = 16'h0000;
      OPAF_LITERAL_MODE:      eff_addr = long_off;               // RULE_14
      OPAF_DIRECT_MODE:       eff_addr = {OPAF_DIRECT_PAGE, byte1}; // RULE_03
      OPAF_FULL_ADDRESS_MODE: eff_addr = opaf_join(byte1, byte2); // RULE_08
      OPAF_POINTER_PLAIN_MODE: eff_addr = index_pair;            // RULE_11
      OPAF_POINTER_AUTOINC_MODE:
      begin
        eff_addr     = index_pair;                               // RULE_11
        index_after  = index_pair + 16'h0001;
        // the spare class code is refused as well, not only the plain class
        mode_illegal = (opaf_class_e'(iclass) != OPAF_CLASS_CMP_BEQ)
                     && (opaf_class_e'(iclass) != OPAF_CLASS_MEM_MOVE); // RULE_11
      end
      OPAF_POINTER_SHORT_MODE: eff_addr = index_pair + short_off; // RULE_09
      OPAF_POINTER_SHORT_INC_MODE:
      begin
        eff_addr     = index_pair + short_off;
        index_after  = index_pair + 16'h0001;
        mode_illegal = (opaf_class_e'(iclass) != OPAF_CLASS_CMP_BEQ); // RULE_12
      end
      OPAF_POINTER_LONG_MODE: eff_addr = index_pair + long_off;  // RULE_10
      OPAF_STACK_SHORT_MODE:  eff_addr = stack_ptr + short_off;  // RULE_13
      OPAF_STACK_LONG_MODE:   eff_addr = stack_ptr + long_off;   // RULE_13
      OPAF_RELATIVE_MODE:     eff_addr = next_pc + rel_off;      // RULE_06
      default:                mode_illegal = 1'b1;
    endcase
    if (mode_illegal)
    begin
      index_after = index_pair;
    end
  end

endmodule : opaf_ea_calc

// File: hdl/opaf_core.sv
// apb-reachable operand addressing and condition flag unit
`timescale 1ns/1ns

// What this block does
// [RULE_01] flags hold V bit 7, H 4, I 3, N 2, Z 1, C 0.
// [RULE_02] carry takes the carry or borrow out of bit 7 of 8-bit sums.
// [RULE_03] direct mode forces high address byte to zero, first 256 locations.
// [RULE_04] 16-bit memory words: high byte at address, low byte next above.
// [RULE_05] word bit 15 is bit 7 of the first, high byte.
// [RULE_06] branch target is next address plus signed offset, -128 to +127.
// [RULE_07] branch offset is the last instruction byte, two's complement.
// [RULE_08] full address mode joins two bytes, high first, into 16 bits.
// [RULE_09] short pointer offset is unsigned, added to the index pair.
// [RULE_10] long pointer offset, high byte first, added to the index pair.
// [RULE_11] plain pointer uses index pair; auto-increment only for compare-branch and move.
// [RULE_12] short-offset auto-increment only for compare-branch-equal.
// [RULE_13] stack modes add an 8 or 16 bit offset to the stack pointer.
// [RULE_14] literals are one byte, or two with the high byte first. The block always joins byte1 and byte2 into a two-byte literal.
// [RULE_15] each flag is kept, cleared, set, updated or undefined per instruction.
// [RULE_16] address sums wrap modulo 65536 with no fault.
module opaf_core
  import opaf_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [15:0] eff_addr,
  output logic             mode_illegal
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0]  flags;
    logic [3:0]  mode;
    logic [1:0]  iclass;
    logic [15:0] index_pair;
    logic [15:0] stack_ptr;
    logic [15:0] next_pc;
    logic [7:0]  byte1;
    logic [7:0]  byte2;
    logic [7:0]  alu_a;
    logic [7:0]  alu_m;
    logic [1:0]  alu_op;
    logic [7:0]  result;
    logic [11:0] policy;
    logic [15:0] mem_word;
    logic [15:0] ea;
    logic        illegal;
    opaf_state_e state;
    logic [31:0] rdata;
    logic        slverr;
  } opaf_state_s;

  opaf_state_s s_q;
  opaf_state_s s_d;

  logic [15:0] ea_w;
  logic [15:0] index_after_w;
  logic        illegal_w;

  opaf_ea_calc u_ea (
    .mode         (s_q.mode),
    .iclass       (s_q.iclass),
    .index_pair   (s_q.index_pair),
    .stack_ptr    (s_q.stack_ptr),
    .next_pc      (s_q.next_pc),
    .byte1        (s_q.byte1),
    .byte2        (s_q.byte2),
    .eff_addr     (ea_w),
    .index_after  (index_after_w),
    .mode_illegal (illegal_w)
  );

  // ==========================================================
  // helpers
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    merge = r;
  endfunction : merge

  function automatic logic apply_pol(input logic [1:0] pol,
                                     input logic       old_b,
                                     input logic       new_b);
    case (opaf_pol_e'(pol))
      OPAF_POL_KEEP:   apply_pol = old_b;
      OPAF_POL_ZERO:   apply_pol = 1'b0;
      OPAF_POL_ONE:    apply_pol = 1'b1;
      default:         apply_pol = new_b;
    endcase
  endfunction : apply_pol

  // ==========================================================
  // alu for flag generation
  logic [8:0]  sum9;
  logic [4:0]  half5;
  logic        cin;
  logic        is_sub;
  logic [7:0]  res8;
  logic        fl_v;
  logic        fl_h;
  logic        fl_c;

  always_comb
  begin
    is_sub = s_q.alu_op[1];
    cin    = s_q.alu_op[0] & s_q.flags[OPAF_FLAG_C];
    if (is_sub)
    begin
      sum9  = {1'b0, s_q.alu_a} - {1'b0, s_q.alu_m} - {8'h00, cin};
      half5 = {1'b0, s_q.alu_a[3:0]} - {1'b0, s_q.alu_m[3:0]} - {4'h0, cin};
    end
    else
    begin
      sum9  = {1'b0, s_q.alu_a} + {1'b0, s_q.alu_m} + {8'h00, cin};
      half5 = {1'b0, s_q.alu_a[3:0]} + {1'b0, s_q.alu_m[3:0]} + {4'h0, cin};
    end
    res8 = sum9[7:0];
    fl_c = sum9[8];                                              // RULE_02
    fl_h = half5[4];
    if (is_sub)
    begin
      fl_v = (s_q.alu_a[7] & ~s_q.alu_m[7] & ~res8[7])
           | (~s_q.alu_a[7] & s_q.alu_m[7] & res8[7]);
    end
    else
    begin
      fl_v = (s_q.alu_a[7] & s_q.alu_m[7] & ~res8[7])
           | (~s_q.alu_a[7] & ~s_q.alu_m[7] & res8[7]);
    end
  end

  // ==========================================================
  // next state
  logic        acc_w;
  logic [31:0] wr_w;
  logic [31:0] cur_w;

  always_comb
  begin
    s_d   = s_q;
    acc_w = psel & penable;
    cur_w = 32'h0000_0000;
    wr_w  = 32'h0000_0000;
    s_d.ea      = ea_w;
    s_d.illegal = illegal_w;

    // flag update sequencer
    case (s_q.state)
      OPAF_ST_IDLE: s_d.state = OPAF_ST_IDLE;
      OPAF_ST_APPLY:
      begin
        s_d.result = res8;
        s_d.flags[OPAF_FLAG_V] = apply_pol(s_q.policy[11:10],
                                           s_q.flags[OPAF_FLAG_V], fl_v); // RULE_15
        s_d.flags[OPAF_FLAG_H] = apply_pol(s_q.policy[9:8],
                                           s_q.flags[OPAF_FLAG_H], fl_h);
        s_d.flags[OPAF_FLAG_I] = apply_pol(s_q.policy[7:6],
                                           s_q.flags[OPAF_FLAG_I], s_q.flags[OPAF_FLAG_I]);
        s_d.flags[OPAF_FLAG_N] = apply_pol(s_q.policy[5:4],
                                           s_q.flags[OPAF_FLAG_N], res8[7]);
        s_d.flags[OPAF_FLAG_Z] = apply_pol(s_q.policy[3:2],
                                           s_q.flags[OPAF_FLAG_Z], res8 == 8'h00);
        s_d.flags[OPAF_FLAG_C] = apply_pol(s_q.policy[1:0],
                                           s_q.flags[OPAF_FLAG_C], fl_c); // RULE_02
        s_d.state = OPAF_ST_DONE;
      end
      OPAF_ST_DONE: s_d.state = OPAF_ST_IDLE;
      default:      s_d.state = OPAF_ST_IDLE;
    endcase

    // decode while selected: reads are captured on the setup edge so prdata
    // leaves a flip-flop with zero wait states; a read shows the setup-edge value
    s_d.rdata = 32'h0000_0000;
    if (psel)
    begin
      s_d.slverr = 1'b0;
      case (paddr)
        OPAF_OFS_FLAGS:   cur_w = {24'h0, s_q.flags};
        OPAF_OFS_MODE:    cur_w = {26'h0, s_q.iclass, s_q.mode};
        OPAF_OFS_INDEX:   cur_w = {16'h0, s_q.index_pair};
        OPAF_OFS_STACK:   cur_w = {16'h0, s_q.stack_ptr};
        OPAF_OFS_NEXTPC:  cur_w = {16'h0, s_q.next_pc};
        OPAF_OFS_OPBYTES: cur_w = {16'h0, s_q.byte1, s_q.byte2};
        OPAF_OFS_EA:      cur_w = {15'h0, s_q.illegal, s_q.ea};
        OPAF_OFS_ALU:     cur_w = {14'h0, s_q.alu_op, s_q.alu_m, s_q.alu_a};
        OPAF_OFS_RESULT:  cur_w = {23'h0, s_q.state == OPAF_ST_IDLE, s_q.result};
        // word bit 15 comes from bit 7 of the byte at the lower address
        OPAF_OFS_MEMWORD: cur_w = {16'h0, s_q.mem_word};         // RULE_04 RULE_05
        OPAF_OFS_POLICY:  cur_w = {20'h0, s_q.policy};
        default:          s_d.slverr = 1'b1;
      endcase
      wr_w = merge(cur_w, pwdata, pstrb);
      s_d.rdata = (!penable && !pwrite) ? cur_w : 32'h0000_0000;
      if (acc_w && pwrite && !s_d.slverr)
      begin
        case (paddr)
          // bits 6 and 5 are fixed at one
          OPAF_OFS_FLAGS:   s_d.flags = wr_w[7:0] | OPAF_FLAGS_ONES; // RULE_01
          OPAF_OFS_MODE:
          begin
            s_d.mode   = wr_w[3:0];
            s_d.iclass = wr_w[5:4];
          end
          OPAF_OFS_INDEX:   s_d.index_pair = wr_w[15:0];
          OPAF_OFS_STACK:   s_d.stack_ptr  = wr_w[15:0];
          OPAF_OFS_NEXTPC:  s_d.next_pc    = wr_w[15:0];
          OPAF_OFS_OPBYTES:
          begin
            s_d.byte1 = wr_w[15:8];
            s_d.byte2 = wr_w[7:0];
          end
          // a write here commits the address use, so post-increment happens now
          OPAF_OFS_EA:      s_d.index_pair = index_after_w;      // RULE_11
          OPAF_OFS_ALU:
          begin
            s_d.alu_a  = wr_w[7:0];
            s_d.alu_m  = wr_w[15:8];
            s_d.alu_op = wr_w[17:16];
            s_d.state  = OPAF_ST_APPLY;
          end
          OPAF_OFS_MEMWORD: s_d.mem_word = opaf_join(wr_w[15:8], wr_w[7:0]); // RULE_04
          OPAF_OFS_POLICY:  s_d.policy   = wr_w[11:0];
          default:          s_d.slverr   = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q        <= '0;
      s_q.flags  <= OPAF_FLAGS_RESET;
      s_q.state  <= OPAF_ST_IDLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  assign pready       = 1'b1;
  assign prdata       = s_q.rdata;
  assign pslverr      = psel & penable & s_d.slverr;
  assign eff_addr     = s_q.ea;
  assign mode_illegal = s_q.illegal;

endmodule : opaf_core

// File: tb/opaf_core_properties.sv
// port assertions for the operand address and flags unit
`timescale 1ns/1ns
module opaf_checker
  import opaf_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] eff_addr,
  input wire logic        mode_illegal
);
  logic acc_wr;
  logic mode_wr;
  assign acc_wr  = psel & penable & pwrite;
  assign mode_wr = acc_wr & pstrb[0] & (paddr == OPAF_OFS_MODE);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // =====================================================
  // mode writes
  // the quiet cycle lets the registered address settle before it is judged
  sequence mode_set_s(logic [3:0] m, logic [1:0] c);
    mode_wr && pwdata[5:0] == {c, m} ##1 !acc_wr;
  endsequence
  sequence odd_mode_s;
    mode_wr && pwdata[3:0] > 4'hB ##1 !acc_wr;
  endsequence
  // =====================================================
  // bus and mode properties
  pready_high_a: assert property (pready) else $error("pready low");
  read_idle_a: assert property (!(psel && penable) |-> prdata == 32'h0 && !pslverr)
    else $error("bus outputs active outside access");
  slverr_map_a: assert property (psel && penable && paddr > OPAF_OFS_POLICY |-> pslverr)
    else $error("unmapped access accepted");
  slverr_ok_a: assert property (psel && penable && paddr <= OPAF_OFS_POLICY
    && paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped access refused");
  flags_ones_a: assert property (psel && penable && !pwrite && paddr == OPAF_OFS_FLAGS
    |-> prdata[31:8] == 24'h0 && prdata[6:5] == 2'b11) else $error("flag layout wrong");
  direct_page_a: assert property (mode_set_s(4'h2, 2'h0) |=> eff_addr[15:8] == 8'h00)
    else $error("direct page not zero");
  odd_mode_a: assert property (odd_mode_s |=> mode_illegal) else $error("unknown mode accepted");
  short_inc_a: assert property (mode_set_s(4'h7, 2'h0) |=> mode_illegal)
    else $error("short autoinc accepted");
  plain_inc_a: assert property (mode_set_s(4'h5, 2'h0) |=> mode_illegal)
    else $error("autoinc accepted");
  legal_inc_a: assert property (mode_set_s(4'h5, 2'h2) |=> !mode_illegal)
    else $error("autoinc refused for move");
endmodule : opaf_checker

// File: tb/opaf_mem_model.sv
// memory partner: bytes over a 16-bit address space
`timescale 1ns/1ns
module opaf_mem_model
(
  input  wire logic [15:0] addr,
  output logic      [15:0] word
);
  logic [7:0] mem [0:65535];
  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'(i) ^ 8'hA5;
  end
  // high byte at the address, low byte one above, wrapping at the top
  assign word = {mem[addr], mem[addr + 16'h0001]};
endmodule : opaf_mem_model

// File: tb/opaf_core_bench.sv
// self-checking bench for the operand address and flags unit
`timescale 1ns/1ns
module opaf_core_bench
  import opaf_pkg::*;
;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [3:0]  pstrb   = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] eff_addr;
  logic        mode_illegal;
  logic [15:0] mem_word;
  int          failures     = 0;
  int          total_checks = 0;
  always #20 pclk = ~pclk;
  opaf_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .eff_addr(eff_addr), .mode_illegal(mode_illegal));
  opaf_mem_model mem (.addr(eff_addr), .word(mem_word));
  // =====================================================
  // tasks
  task automatic wrap_up;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      failures++;
      wrap_up();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask : rd
  // =====================================================
  // expectations
  function automatic logic [15:0] exp_ea(input logic [3:0] m, input logic [15:0] x, s, p,
                                         input logic [7:0] b1, b2);
    case (m)
      4'h1, 4'h3: return {b1, b2};
      4'h2: return {8'h00, b1};
      4'h4, 4'h5: return x;
      4'h6, 4'h7: return x + {8'h00, b1};
      4'h8: return x + {b1, b2};
      4'h9: return s + {8'h00, b1};
      4'hA: return s + {b1, b2};
      default: return p + {{8{b1[7]}}, b1};
    endcase
  endfunction : exp_ea
  function automatic logic exp_ill(input logic [3:0] m, input logic [1:0] c);
    return (m > 4'hB) || (m == 4'h5 && c != 2'h1 && c != 2'h2)
      || (m == 4'h7 && c != 2'h1);
  endfunction : exp_ill
  function automatic logic [7:0] exp_flags(input logic [7:0] f, a, m, input logic [1:0] op,
                                           input logic [11:0] pol, output logic [7:0] r);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] rf;
    logic [7:0] o;
    int         b;
    s = op[1] ? {1'b0, a} - {1'b0, m} - 9'(op[0] & f[0])
              : {1'b0, a} + {1'b0, m} + 9'(op[0] & f[0]);
    h = {1'b0, a[3:0]} + {1'b0, m[3:0]} + 5'(op[0] & f[0]);
    r = s[7:0];
    rf = {op[1] ? (a[7] & ~m[7] & ~r[7] | ~a[7] & m[7] & r[7])
                : (a[7] & m[7] & ~r[7] | ~a[7] & ~m[7] & r[7]),
          2'b11, h[4], f[3], r[7], r == 8'h00, s[8]};
    o = f | OPAF_FLAGS_ONES;
    for (int k = 0; k < 6; k++)
    begin
      b = (k == 5) ? 7 : k;
      case (pol[2 * k +: 2])
        2'h1: o[b] = 1'b0;
        2'h2: o[b] = 1'b1;
        2'h3: o[b] = rf[b];
        default: o[b] = o[b];
      endcase
    end
    return o;
  endfunction : exp_flags
  // =====================================================
  // main sequence
  initial
  begin
    logic [31:0] q;
    logic        e;
    logic [15:0] x, s, p, ea;
    logic [7:0]  b1, b2, fl, a, m, r;
    logic [3:0]  md;
    logic [1:0]  cl, op;
    logic [11:0] pol;
    logic        il;
    void'($urandom(56));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(OPAF_OFS_FLAGS, q);
    check("flags at reset", 32'h68, q);
    wr(OPAF_OFS_FLAGS, 32'h9F);
    fl = 8'hFF;
    rd(OPAF_OFS_FLAGS, q);
    check("flags written", {24'h0, fl}, q);
    apb(1'b0, 12'h02C, 32'h0, q, e);
    check("unmapped error", 32'h1, {31'h0, e});
    check("unmapped data", 32'h0, q);
    apb(1'b1, 12'hFFC, 32'h0, q, e);
    check("unmapped write error", 32'h1, {31'h0, e});
    rd(OPAF_OFS_FLAGS, q);
    check("flags after stray write", {24'h0, fl}, q);
    // every mode code under classes 0 to 2; class 1 sits at the top of memory to force wraps
    for (int i = 0; i < 48; i++)
    begin
      md = 4'(i);
      cl = 2'(i / 16);
      x  = (cl == 2'h1) ? 16'hFFFF : 16'($urandom);
      s  = (cl == 2'h1) ? 16'hFFF0 : 16'($urandom);
      p  = 16'($urandom);
      b1 = 8'($urandom);
      b2 = 8'($urandom);
      il = exp_ill(md, cl);
      ea = exp_ea(md, x, s, p, b1, b2);
      wr(OPAF_OFS_INDEX, {16'h0, x});
      wr(OPAF_OFS_STACK, {16'h0, s});
      wr(OPAF_OFS_NEXTPC, {16'h0, p});
      wr(OPAF_OFS_OPBYTES, {16'h0, b1, b2});
      wr(OPAF_OFS_MODE, {26'h0, cl, md});
      rd(OPAF_OFS_EA, q);
      check("illegal flag", {31'h0, il}, {31'h0, q[16]});
      check("illegal port", {31'h0, il}, {31'h0, mode_illegal});
      if (md != 4'h0 && md <= 4'hB)
      begin
        check("ea read", {16'h0, ea}, {16'h0, q[15:0]});
        check("ea port", {16'h0, ea}, {16'h0, eff_addr});
      end
      if (md == 4'h5 || md == 4'h7)
      begin
        wr(OPAF_OFS_EA, 32'h0);
        rd(OPAF_OFS_INDEX, q);
        check("index after use", {16'h0, il ? x : x + 16'h0001}, q);
      end
    end
    wr(OPAF_OFS_OPBYTES, 32'h0000_FF00);
    wr(OPAF_OFS_MODE, 32'h2);
    rd(OPAF_OFS_EA, q);
    check("direct page", 32'h00FF, {16'h0, eff_addr});
    wr(OPAF_OFS_MEMWORD, {16'h0, mem_word});
    rd(OPAF_OFS_MEMWORD, q);
    check("word from memory", 32'h5AA5, q);
    // interrupt mask and subtract half carry are undefined when taken from the result
    for (int i = 0; i < 40; i++)
    begin
      op  = 2'(i);
      a   = (i < 8) ? 8'hFF : 8'($urandom);
      m   = (i < 8) ? 8'(i % 8) : 8'($urandom);
      pol = (i < 8) ? 12'hF3F : 12'($urandom);
      if (pol[7:6] == 2'h3)
        pol[7:6] = 2'h0;
      if (op[1] && pol[9:8] == 2'h3)
        pol[9:8] = 2'h0;
      wr(OPAF_OFS_POLICY, {20'h0, pol});
      wr(OPAF_OFS_ALU, {14'h0, op, m, a});
      q = 32'h0;
      for (int n = 0; n < 20 && q[8] !== 1'b1; n++)
        rd(OPAF_OFS_RESULT, q);
      if (q[8] !== 1'b1)
      begin
        failures++;
        wrap_up();
      end
      fl = exp_flags(fl, a, m, op, pol, r);
      check("alu result", {24'h0, r}, {24'h0, q[7:0]});
      rd(OPAF_OFS_FLAGS, q);
      check("flags after alu", {24'h0, fl}, q);
    end
    wrap_up();
  end
endmodule : opaf_core_bench
bind opaf_core opaf_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .eff_addr(eff_addr),
  .mode_illegal(mode_illegal));
